/* sfd_pkg.sv */
// Constants, carrier types and state layout of the speaker fault
// diagnostics block.
// Assumes a 50 MHz clock and analog comparators that present their
// verdicts as level pins, one bit per channel.
//
// Functional notes
// - Latch output status after 100 ms pulse
// - Restart mode: per-channel shutdown, 1 ms recheck
// - Diagnostic mode enabled by host, trips start it
// - 1 ms recheck clear returns channel active
// - Overload persists: run 100 ms diagnostic cycle
// - After cycle: restart mode, results stored
// - No new cycle until host reads results
// - Flag channels with DC offset beyond 2 V
// - Offset window: enable or last read to read
// - Offset reported only if persistent whole window
// - Overload trip suspends offset and AC tests
// - AC detection only while enable bit set
// - Threshold bit selects AC current limits
// - Under three pulses in period: open tweeter
// - Several faults: at least one reported first
// - Double-fault priority table decides reported fault
// - Source/sink side depends on channel number
// - Permanent diagnostics never report open load
// - Fault reported only if stable whole period
// - Each read re-arms cycles, returns stored results (here only reads of the result register do)
// - Standby out with diag: pulse before bias
// - Cycle-done flag set when cycle terminates
package sfd_pkg;
    localparam int unsigned NCH = 4;
    localparam int unsigned CNT_W = 23;
    localparam int unsigned CLK_HZ = 50_000_000;
    // Times in milliseconds; cycle counts derived from the clock rate
    localparam int unsigned RECHECK_MS = 1;
    localparam int unsigned DIAG_MS = 100;
    localparam int unsigned ACQ_MS = 100;
    localparam logic [CNT_W-1:0] RECHECK_CYC = CNT_W'(CLK_HZ / 1000 * RECHECK_MS);
    localparam logic [CNT_W-1:0] DIAG_CYC = CNT_W'(CLK_HZ / 1000 * DIAG_MS);
    localparam logic [CNT_W-1:0] ACQ_CYC = CNT_W'(CLK_HZ / 1000 * ACQ_MS);
    localparam logic [CNT_W-1:0] CNT_ONE = 23'h000001;
    localparam logic [1:0] PULSE_MIN = 2'h3;
    // Byte addresses of the registers
    localparam logic [3:0] ADR_CTRL = 4'h0;
    localparam logic [3:0] ADR_STAT = 4'h4;
    localparam logic [3:0] ADR_RES = 4'h8;
    // Control register fields
    localparam int unsigned CTRL_DIAG = 0;
    localparam int unsigned CTRL_OFFS = 1;
    localparam int unsigned CTRL_CUR = 2;
    localparam int unsigned CTRL_THR = 3;
    localparam int unsigned CTRL_STBY = 4;
    localparam logic [4:0] CTRL_RST = 5'h00;
    // Fault code bits, also the low nibble of each result byte
    localparam int unsigned FC_GND = 0;
    localparam int unsigned FC_VS = 1;
    localparam int unsigned FC_ACR = 2;
    localparam int unsigned FC_OPEN = 3;
    localparam int unsigned RB_OFFS = 4;
    localparam int unsigned RB_TWT = 5;
    localparam int unsigned CH_STRIDE = 8;
    localparam int unsigned RES_DONE = 31;
    // Status register fields
    localparam int unsigned ST_DONE = 0;
    localparam int unsigned ST_BIAS = 1;
    localparam int unsigned ST_CHON = 4;

    typedef struct packed {
        logic [3:0] trip;
        logic [3:0] pulse;
        logic [3:0] offs;
        logic [3:0] open;
        logic [3:0] across;
        logic [3:0] vs;
        logic [3:0] gnd_neg;
        logic [3:0] gnd_pos;
    } sfd_pins_t;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [3:0] adr;
        logic [31:0] dat;
    } sfd_wb_req_t;
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } sfd_wb_rsp_t;
    typedef struct packed {
        logic [3:0] ch_on;
        logic test_pulse;
        logic bias;
        logic hiz;
        logic thr_low;
    } sfd_amp_t;
    typedef enum logic [1:0] {T_STBY, T_PULSE, T_BIAS} sfd_top_st_t;
    typedef enum logic [1:0] {C_ACT, C_CHK, C_DIAG} sfd_ch_st_t;
    typedef struct packed {
        sfd_pins_t s1;
        sfd_pins_t s2;
        sfd_pins_t s3;
        sfd_pins_t flt;
        logic [3:0] pul_d;
        logic [4:0] ctrl;
        sfd_top_st_t tst;
        logic [CNT_W-1:0] tcnt;
        logic [3:0][3:0] tcode;
        logic tstab;
        sfd_ch_st_t [3:0] cst;
        logic [3:0][CNT_W-1:0] ccnt;
        logic [3:0][3:0] ccode;
        logic [3:0] cstab;
        logic done;
        logic [3:0][3:0] res;
        logic [3:0] off_ok;
        logic off_susp;
        logic ac_susp;
        logic [3:0][1:0] pcnt;
        sfd_wb_rsp_t rsp;
        sfd_amp_t amp;
    } sfd_state_t;
    localparam sfd_state_t ST_RST = '0;
endpackage

/* sfd_properties.sv */
// Concurrent checks on the ports of the speaker fault diagnostics top.
// Assumes the bench hands over the shortened recheck and pulse counts.
`timescale 1ns/10ps
`default_nettype none
module sfd_properties
    import sfd_pkg::*;
#(
    parameter logic [CNT_W-1:0] MS_CYC = RECHECK_CYC,
    parameter logic [CNT_W-1:0] DG_CYC = DIAG_CYC,
    parameter logic [CNT_W-1:0] AQ_CYC = ACQ_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire sfd_wb_req_t wb_req,
    input wire sfd_wb_rsp_t wb_rsp,
    input wire sfd_pins_t pins,
    input wire sfd_amp_t amp
);
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Master request present on the bus
    wire logic req = wb_req.cyc && wb_req.stb;

    chk_ack_next: assert property (req && !wb_rsp.ack |=> wb_rsp.ack)
        else $error("ack did not follow a request by one cycle");
    chk_ack_single: assert property (wb_rsp.ack |=> !wb_rsp.ack)
        else $error("ack held longer than one cycle");
    chk_pulse_hiz: assert property (amp.test_pulse |-> amp.hiz && !amp.bias)
        else $error("test pulse while outputs driven");
    chk_bias_drive: assert property (amp.bias |-> !amp.hiz)
        else $error("biased amplifier with floating outputs");
    chk_pulse_min: assert property ($rose(amp.test_pulse) |-> amp.test_pulse [*8])
        else $error("turn-on pulse cut short");
    // Sync and filter delay plus two cycles of margin before the channel must drop
    chk_trip_off: assert property (pins.trip[0] [*7] |=> !amp.ch_on[0])
        else $error("tripped channel kept playing");
    chk_recheck_gap: assert property ($fell(amp.ch_on[0]) |=> !amp.ch_on[0] [*7])
        else $error("channel came back before the recheck time");
    chk_on_clear: assert property ($rose(amp.ch_on[0]) |-> !$past(pins.trip[0], 3))
        else $error("channel restarted while still overloaded");
    chk_thr_ctrl: assert property (req && wb_req.we && wb_rsp.ack && wb_req.adr == ADR_CTRL
        && wb_req.sel[0] |=> amp.thr_low == $past(wb_req.dat[CTRL_THR]))
        else $error("threshold output differs from written control bit");
    chk_unmapped: assert property (req && !wb_req.we && wb_rsp.ack && wb_req.adr == 4'hc
        |-> wb_rsp.dat == 32'h0)
        else $error("unmapped read returned nonzero data");
endmodule
bind sfd_top sfd_properties #(.MS_CYC(MS_CYC), .DG_CYC(DG_CYC), .AQ_CYC(AQ_CYC)) u_chk (
    .clk(clk), .rst(rst), .wb_req(wb_req), .wb_rsp(wb_rsp), .pins(pins), .amp(amp));
`default_nettype wire

/* sfd_tone.sv */
// Model of the host test tone as seen by the current comparators.
// Assumes the bench pulses go for one cycle and then waits 45 cycles.
`timescale 1ns/10ps
`default_nettype none
module sfd_tone (
    input wire logic clk,
    input wire logic go,
    input wire logic [3:0][2:0] cnt,
    output logic [3:0] pulse = 4'h0
);
    // Each channel sees cnt current peaks, four cycles high then four low,
    // and the line rests low between bursts so no stale peak is counted
    always @(posedge clk) begin
        if (go) begin
            for (int k = 0; k < 8; k++) begin
                for (int c = 0; c < 4; c++) begin
                    pulse[c] <= !k[0] && (k / 2 < cnt[c]);
                end
                repeat (4) @(posedge clk);
            end
        end
    end
endmodule
`default_nettype wire

/* sfd_top.sv */
// Speaker fault diagnostics sequencer with a classic Wishbone slave.
// Assumes fault pins come from asynchronous analog comparators and the
// amplifier stage obeys the channel enable, bias and pulse outputs.
//
// The Wishbone slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module sfd_top
    import sfd_pkg::*;
#(
    parameter logic [CNT_W-1:0] MS_CYC = RECHECK_CYC,
    parameter logic [CNT_W-1:0] DG_CYC = DIAG_CYC,
    parameter logic [CNT_W-1:0] AQ_CYC = ACQ_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire sfd_wb_req_t wb_req,
    output var sfd_wb_rsp_t wb_rsp,
    input wire sfd_pins_t pins,
    output var sfd_amp_t amp
);
    sfd_state_t q; // Registered state
    sfd_state_t n; // Next state
    logic bus_go; // New bus request this cycle
    logic rd_res; // Host read of the results
    logic done_set; // A cycle terminated
    logic [3:0][3:0] code_now; // Permanent fault codes
    logic [3:0][3:0] ton_now; // Turn-on fault codes
    logic [3:0][3:0] res_set; // Codes stored this cycle
    logic [3:0] edge_p; // Rising current pulses
    logic [31:0] rd_word; // Result word for the host

    // Pick the source or sink output of a channel
    function automatic logic side(input int c, input logic [3:0] pos,
                                  input logic [3:0] neg, input logic src);
        logic srcpos;
        srcpos = (c == 1) || (c == 2);
        return (srcpos == src) ? pos[c] : neg[c];
    endfunction

    // Reduce simultaneous faults to the reported code
    function automatic logic [3:0] classify(input logic so,
        input logic test_current_sink_side, input logic vs, input logic ac,
        input logic op, input logic perm);
        logic [3:0] r;
        r = 4'h0;
        // Supply short dominates; source ground adds to it
        if (vs) begin
            r[FC_VS] = 1'b1;
            r[FC_GND] = so;
        // Sink ground with open load shows the open load
        end else if (test_current_sink_side && op && !so && !perm) begin
            r[FC_OPEN] = 1'b1;
        end else if (so || test_current_sink_side) begin
            r[FC_GND] = 1'b1;
        end else if (ac) begin
            r[FC_ACR] = 1'b1;
        // Permanent checks cannot see an open load
        end else if (op && !perm) begin
            r[FC_OPEN] = 1'b1;
        end
        return r;
    endfunction

    // Next-state logic for the whole block
    always_comb begin
        n = q;
        done_set = 1'b0;
        res_set = '0;
        rd_word = '0;
        code_now = '0;
        ton_now = '0;
        bus_go = wb_req.cyc && wb_req.stb && !q.rsp.ack;
        rd_res = bus_go && !wb_req.we && (wb_req.adr == ADR_RES);
        // Three-stage sync; a level counts once stages two and three agree
        n.s1 = pins;
        n.s2 = q.s1;
        n.s3 = q.s2;
        n.flt = sfd_pins_t'((q.s2 & q.s3) | (q.flt & (q.s2 ^ q.s3)));
        n.pul_d = q.flt.pulse;
        edge_p = q.flt.pulse & ~q.pul_d;
        // Classify every channel for both kinds of diagnostic
        for (int c = 0; c < NCH; c++) begin
            code_now[c] = classify(side(c, q.flt.gnd_pos, q.flt.gnd_neg, 1'b1),
                side(c, q.flt.gnd_pos, q.flt.gnd_neg, 1'b0), q.flt.vs[c],
                q.flt.across[c], q.flt.open[c], 1'b1);
            ton_now[c] = classify(side(c, q.flt.gnd_pos, q.flt.gnd_neg, 1'b1),
                side(c, q.flt.gnd_pos, q.flt.gnd_neg, 1'b0), q.flt.vs[c],
                q.flt.across[c], q.flt.open[c], 1'b0);
        end

        // Control register write
        if (bus_go && wb_req.we && wb_req.adr == ADR_CTRL && wb_req.sel[0]) begin
            n.ctrl = wb_req.dat[4:0];
        end

        // Turn-on sequencing: the pulse runs while outputs float
        unique case (q.tst)
            T_STBY: begin
                if (q.ctrl[CTRL_STBY]) begin
                    if (q.ctrl[CTRL_DIAG] && !q.done) begin
                        n.tst = T_PULSE;
                        n.tcnt = AQ_CYC - CNT_ONE;
                        n.tcode = ton_now;
                        n.tstab = 1'b1;
                    end else begin
                        n.tst = T_BIAS;
                    end
                end
            end
            T_PULSE: begin
                if (!q.ctrl[CTRL_STBY]) begin
                    n.tst = T_STBY;
                end else begin
                    // Any change during acquisition spoils the result
                    if (ton_now != q.tcode) begin
                        n.tstab = 1'b0;
                    end
                    if (q.tcnt != '0) begin
                        n.tcnt = q.tcnt - CNT_ONE;
                    end else begin
                        // Sample at the end of the pulse top
                        if (q.tstab && ton_now == q.tcode) begin
                            res_set = q.tcode;
                        end
                        done_set = 1'b1;
                        n.tst = T_BIAS;
                    end
                end
            end
            T_BIAS: begin
                if (!q.ctrl[CTRL_STBY]) begin
                    n.tst = T_STBY;
                end
            end
        endcase

        // Permanent diagnostics, one independent machine per channel
        for (int c = 0; c < NCH; c++) begin
            if (q.tst != T_BIAS) begin
                n.cst[c] = C_ACT;
            end else begin
                unique case (q.cst[c])
                    C_ACT: begin
                        // Trip shuts only this channel down
                        if (q.flt.trip[c]) begin
                            n.cst[c] = C_CHK;
                            n.ccnt[c] = MS_CYC - CNT_ONE;
                        end
                    end
                    C_CHK: begin
                        if (q.ccnt[c] != '0) begin
                            n.ccnt[c] = q.ccnt[c] - CNT_ONE;
                        end else if (!q.flt.trip[c]) begin
                            // Overload gone: back to play
                            n.cst[c] = C_ACT;
                        end else if (q.ctrl[CTRL_DIAG] && !q.done) begin
                            // Overload persists: measure it
                            n.cst[c] = C_DIAG;
                            n.ccnt[c] = DG_CYC - CNT_ONE;
                            n.ccode[c] = code_now[c];
                            n.cstab[c] = 1'b1;
                        end else begin
                            // Locked or no diagnostics: recheck each ms
                            n.ccnt[c] = MS_CYC - CNT_ONE;
                        end
                    end
                    C_DIAG: begin
                        if (code_now[c] != q.ccode[c]) begin
                            n.cstab[c] = 1'b0;
                        end
                        if (q.ccnt[c] != '0) begin
                            n.ccnt[c] = q.ccnt[c] - CNT_ONE;
                        end else begin
                            if (q.cstab[c] && code_now[c] == q.ccode[c]) begin
                                res_set[c] = res_set[c] | q.ccode[c];
                            end
                            done_set = 1'b1;
                            // Channel falls back to restart mode
                            n.cst[c] = C_CHK;
                            n.ccnt[c] = MS_CYC - CNT_ONE;
                        end
                    end
                    default: begin
                        n.cst[c] = C_ACT;
                    end
                endcase
            end
            n.amp.ch_on[c] = (n.tst == T_BIAS) && (n.cst[c] == C_ACT);
        end

        // Offset window: reopened while disabled or at a read, else narrowed
        if (!q.ctrl[CTRL_OFFS] || rd_res) begin
            n.off_ok = '1;
            n.off_susp = 1'b0;
        end
        // The read cycle already belongs to the new window, so a trip or a
        // missing offset in that cycle is not lost to the clear
        if (q.ctrl[CTRL_OFFS]) begin
            n.off_ok = n.off_ok & q.flt.offs;
            if (|q.flt.trip) begin
                n.off_susp = 1'b1;
            end
        end

        // Current pulse counting over the measuring period
        if (!q.ctrl[CTRL_CUR] || rd_res) begin
            n.pcnt = '0;
            n.ac_susp = 1'b0;
        end
        // A pulse or trip in the read cycle counts toward the new period
        if (q.ctrl[CTRL_CUR]) begin
            for (int c = 0; c < NCH; c++) begin
                // Saturate; only the third pulse matters
                if (edge_p[c] && n.pcnt[c] != PULSE_MIN) begin
                    n.pcnt[c] = n.pcnt[c] + 2'h1;
                end
            end
            if (|q.flt.trip) begin
                n.ac_susp = 1'b1;
            end
        end

        // Result word as seen at this read
        for (int c = 0; c < NCH; c++) begin
            rd_word[c*CH_STRIDE +: 4] = q.res[c];
            rd_word[c*CH_STRIDE + RB_OFFS] = q.ctrl[CTRL_OFFS] && !q.off_susp
                && q.off_ok[c];
            rd_word[c*CH_STRIDE + RB_TWT] = q.ctrl[CTRL_CUR] && !q.ac_susp
                && (q.pcnt[c] != PULSE_MIN);
        end
        rd_word[RES_DONE] = q.done;

        // Stored results; a new set beats the read's clear
        for (int c = 0; c < NCH; c++) begin
            n.res[c] = res_set[c] | (rd_res ? 4'h0 : q.res[c]);
        end
        n.done = done_set || (q.done && !rd_res);

        // Bus answer one cycle after the request, then dropped
        n.rsp.ack = bus_go;
        if (bus_go && !wb_req.we) begin
            unique case (wb_req.adr)
                ADR_CTRL: n.rsp.dat = {27'h0, q.ctrl};
                ADR_STAT: begin
                    n.rsp.dat = '0;
                    n.rsp.dat[ST_DONE] = q.done;
                    n.rsp.dat[ST_BIAS] = q.amp.bias;
                    n.rsp.dat[ST_CHON +: 4] = q.amp.ch_on;
                end
                ADR_RES: n.rsp.dat = rd_word;
                default: n.rsp.dat = '0;
            endcase
        end

        // Amplifier controls
        n.amp.test_pulse = (n.tst == T_PULSE);
        n.amp.bias = (n.tst == T_BIAS);
        n.amp.hiz = (n.tst != T_BIAS);
        n.amp.thr_low = n.ctrl[CTRL_THR];
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= ST_RST;
        end else begin
            q <= n;
        end
    end

    assign wb_rsp = q.rsp;
    assign amp = q.amp;
endmodule
`default_nettype wire

/* speaker_fault_diagnostics_tb.sv */
// Self-checking bench for the speaker fault diagnostics block.
// Assumes shortened counts: 8-cycle recheck, 40-cycle diagnostic and pulse.
`timescale 1ns/10ps
`default_nettype none
module speaker_fault_diagnostics_tb
    import sfd_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    sfd_wb_req_t req = '0;
    sfd_wb_rsp_t rsp;
    sfd_pins_t pin_v = '0;
    sfd_pins_t pins_in;
    sfd_amp_t amp;
    logic go = 1'b0;
    logic [3:0][2:0] cnt = '0;
    logic [3:0] tone;
    logic [31:0] q;
    int fails = 0;
    int cmp_count = 0;
    int cycles = 0;

    // 50 MHz clock
    always #10 clk = ~clk;
    // Current peaks come from the tone model, the rest from the bench
    always_comb begin
        pins_in = pin_v;
        pins_in.pulse = tone;
    end

    sfd_top #(.MS_CYC(23'h8), .DG_CYC(23'h28), .AQ_CYC(23'h28)) dut (
        .clk(clk), .rst(rst), .wb_req(req), .wb_rsp(rsp), .pins(pins_in), .amp(amp));
    sfd_tone u_tone (.clk(clk), .go(go), .cnt(cnt), .pulse(tone));

    // Compare and count
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task end_sim;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Classic cycle: hold until ack is sampled, then one idle cycle
    task bus(input logic we, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
        do begin
            @(posedge clk);
            n++;
        end while (rsp.ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            $display("[ERR] %0t: no bus acknowledge", $time);
        end
        q = rsp.dat;
        req <= '0;
        @(posedge clk);
    endtask

    // A hang counts as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            $display("[ERR] %0t: run timed out", $time);
            end_sim();
        end
    end

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk(amp.hiz, 32'h1);
        // Register readback and an unmapped place
        bus(1'b1, ADR_CTRL, 32'h0000000c);
        bus(1'b0, ADR_CTRL, 32'h0);
        chk(q, 32'h0000000c);
        chk(amp.thr_low, 32'h1);
        bus(1'b1, 4'hc, 32'hffffffff);
        bus(1'b0, 4'hc, 32'h0);
        chk(q, 32'h0);
        // Turn-on with an open speaker on channel two
        pin_v.open[1] <= 1'b1;
        // Let the open load pass the input filter before the pulse samples it
        repeat (5) @(posedge clk);
        bus(1'b1, ADR_CTRL, 32'h00000011);
        repeat (5) @(posedge clk);
        chk(amp.test_pulse, 32'h1);
        chk(amp.hiz, 32'h1);
        repeat (60) @(posedge clk);
        chk(amp.bias, 32'h1);
        chk(amp.ch_on, 32'hf);
        // Status has no side effect: done, bias and all channels on
        bus(1'b0, ADR_STAT, 32'h0);
        chk(q, 32'h000000f3);
        bus(1'b0, ADR_RES, 32'h0);
        chk(q, 32'h80000800);
        bus(1'b0, ADR_RES, 32'h0);
        chk(q, 32'h0);
        // Short overload clears by the recheck
        pin_v.trip[0] <= 1'b1;
        repeat (6) @(posedge clk);
        pin_v.trip[0] <= 1'b0;
        repeat (30) @(posedge clk);
        chk(amp.ch_on, 32'hf);
        bus(1'b0, ADR_RES, 32'h0);
        chk(q, 32'h0);
        // Lasting supply and source-side ground short on channel three
        pin_v.trip[2] <= 1'b1;
        pin_v.vs[2] <= 1'b1;
        pin_v.gnd_pos[2] <= 1'b1;
        repeat (20) @(posedge clk);
        chk(amp.ch_on, 32'hb);
        repeat (80) @(posedge clk);
        // Second fault while results wait unread
        pin_v.trip[0] <= 1'b1;
        pin_v.gnd_neg[0] <= 1'b1;
        repeat (80) @(posedge clk);
        pin_v <= '0;
        repeat (30) @(posedge clk);
        chk(amp.ch_on, 32'hf);
        bus(1'b0, ADR_RES, 32'h0);
        chk(q, 32'h80030000);
        bus(1'b0, ADR_RES, 32'h0);
        chk(q, 32'h0);
        // Offset window on channel four
        pin_v.offs[3] <= 1'b1;
        repeat (10) @(posedge clk);
        bus(1'b1, ADR_CTRL, 32'h00000013);
        repeat (20) @(posedge clk);
        bus(1'b0, ADR_RES, 32'h0);
        chk(q, 32'h10000000);
        pin_v.offs[3] <= 1'b0;
        repeat (6) @(posedge clk);
        pin_v.offs[3] <= 1'b1;
        repeat (10) @(posedge clk);
        bus(1'b0, ADR_RES, 32'h0);
        chk(q, 32'h0);
        // Tone with 3, 2, 0, 0 peaks at the low threshold
        pin_v.offs[3] <= 1'b0;
        bus(1'b1, ADR_CTRL, 32'h0000001d);
        chk(amp.thr_low, 32'h1);
        cnt <= {3'h0, 3'h0, 3'h2, 3'h3};
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (45) @(posedge clk);
        bus(1'b0, ADR_RES, 32'h0);
        chk(q, 32'h20202000);
        bus(1'b0, ADR_RES, 32'h0);
        chk(q, 32'h20202020);
        // Overload during the measuring period
        pin_v.trip[1] <= 1'b1;
        repeat (6) @(posedge clk);
        pin_v.trip[1] <= 1'b0;
        repeat (30) @(posedge clk);
        bus(1'b0, ADR_RES, 32'h0);
        chk(q, 32'h0);
        // Current detection switched off
        bus(1'b1, ADR_CTRL, 32'h00000019);
        bus(1'b0, ADR_RES, 32'h0);
        bus(1'b0, ADR_RES, 32'h0);
        chk(q, 32'h0);
        end_sim();
    end
endmodule
`default_nettype wire
